/* oob_framer_pkg.sv */
// Constants, field layouts and carrier types for the out-of-band cell framer
package oob_framer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] TRAILER_OFS = 12'h008;
  localparam logic [11:0] CHAN_SEL_OFS = 12'h00C;
  localparam logic [11:0] CHAN_INFO_OFS = 12'h010;
  localparam logic [11:0] FLAG_BASE_OFS = 12'h040;
  localparam logic [11:0] FLAG_LAST_OFS = 12'h07C;

  localparam logic [15:0] TRAILER_RST = 16'h0000;
  localparam logic [5:0] CHAN_SEL_RST = 6'h01;

  // ----------------------------------------------------------------
  // Coding constants
  // ----------------------------------------------------------------
  localparam logic [7:0] HEC_COSET = 8'h55;
  localparam logic [7:0] HEC_POLY_LOW = 8'h07;
  localparam logic [7:0] GF_POLY_LOW = 8'h1D;
  localparam logic [5:0] CRC6_POLY_LOW = 6'h03;
  localparam logic [5:0] HDR_LAST = 6'd3;
  localparam logic [5:0] HEC_POS = 6'd4;
  localparam logic [5:0] CELL_BYTES = 6'd53;
  localparam logic [5:0] CODE_LAST = 6'd54;
  localparam int RS_SHORTEN = 200;

  // ----------------------------------------------------------------
  // Interleaver and payload layout
  // ----------------------------------------------------------------
  localparam int IL_DEPTH = 5;
  localparam int IL_M = 11;
  localparam int IL_CELLS = 110;
  localparam logic [2:0] IL_BRANCH_LAST = 3'd4;
  localparam logic [3:0] ROW_LAST = 4'd9;
  localparam logic [2:0] SET_LAST = 3'd7;
  localparam logic [1:0] SET_BYTE_LAST = 2'd2;
  localparam logic [4:0] FLAG_IDX_MAX = 5'd16;
  localparam logic [5:0] BOUNDARY_WIDE = 6'd55;

  typedef enum {SEQ_LEAD, SEQ_CODED, SEQ_TAIL} seq_state_t;

  // Bit k of the packed set is flag bit k
  typedef struct packed {
    logic [5:0] crc;
    logic [1:0] resv_ctrl;
    logic [8:0] rx_ind;
    logic [5:0] boundary_code_bits;
    logic ranging_indicator_bit;
  } flag_set_t;

  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic coded;
  } out_beat_t;

endpackage

/* oob_framer.sv */
// Downstream payload framer: HEC, RS(55,53), depth-5 interleaver, MAC flag sets
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module oob_framer (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] CELL_DATA_I,
  input wire logic CELL_VALID_I,
  output logic CELL_READY_O,
  output oob_framer_pkg::out_beat_t OUT_BEAT_O,
  output logic OUT_VALID_O,
  input wire logic OUT_READY_I
);
  import oob_framer_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] gf_mul2(input logic [7:0] x);
    gf_mul2 = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY_LOW : 8'h00);
  endfunction

  function automatic logic [7:0] hec_step(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] r;
    logic fb;
    r = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = r[7] ^ b[i];
      r = {r[6:0], 1'b0} ^ (fb ? HEC_POLY_LOW : 8'h00);
    end
    hec_step = r;
  endfunction

  // Remainder bit 5 (first sent) lands on flag bit 18
  function automatic logic [5:0] flag_crc(input logic [17:0] d);
    logic [5:0] r;
    logic fb;
    r = 6'h00;
    for (int i = 0; i < 18; i++) begin
      fb = r[5] ^ d[i];
      r = {r[4:0], 1'b0} ^ (fb ? CRC6_POLY_LOW : 6'h00);
    end
    for (int i = 0; i < 6; i++) begin
      flag_crc[i] = r[5 - i];
    end
  endfunction

  function automatic logic [7:0] flag_byte(input flag_set_t s, input logic [1:0] k);
    logic [23:0] v;
    v = s;
    flag_byte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      flag_byte[7 - i] = v[8 * k + i];
    end
  endfunction

  function automatic logic [6:0] il_base(input int j);
    il_base = 7'(IL_M * j * (j - 1) / 2);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic enable_q;
  logic [15:0] trailer_q;
  logic [5:0] chan_sel_q;
  flag_set_t flags_q [16];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [15:0] sf_count_q;
  logic [15:0] cell_count_q;
  logic sf_b_q;

  wire [11:0] ofs = PADDR_I[11:0];
  wire page_ok = (PADDR_I[31:12] == 20'h0_0000) && (ofs[1:0] == 2'b00);
  wire hit_ctrl = page_ok && (ofs == CTRL_OFS);
  wire hit_status = page_ok && (ofs == STATUS_OFS);
  wire hit_trailer = page_ok && (ofs == TRAILER_OFS);
  wire hit_sel = page_ok && (ofs == CHAN_SEL_OFS);
  wire hit_info = page_ok && (ofs == CHAN_INFO_OFS);
  wire hit_flag = page_ok && (ofs >= FLAG_BASE_OFS) && (ofs <= FLAG_LAST_OFS);
  wire hit_any = hit_ctrl | hit_status | hit_trailer | hit_sel | hit_info | hit_flag;
  wire [3:0] flag_idx = ofs[5:2];
  wire apb_setup = PSEL_I & ~PENABLE_I;
  wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I & hit_any;

  // ----------------------------------------------------------------
  // Channel flag query
  // ----------------------------------------------------------------
  wire [4:0] chan_idx = chan_sel_q[4:0];
  wire chan_fast = chan_sel_q[5];
  wire [5:0] chan_sets = chan_fast ? 6'd4 : 6'd2;
  wire [5:0] chan_end = 6'(chan_idx) + chan_sets - 6'd1;
  wire chan_idx_ok = (chan_idx != 5'd0) && (chan_idx <= FLAG_IDX_MAX);
  wire chan_valid = chan_idx_ok && (chan_end <= 6'(FLAG_IDX_MAX));
  wire [3:0] chan_first = chan_idx[3:0] - 4'd1;
  flag_set_t chan_set;
  assign chan_set = flags_q[chan_first];
  // codes 55-63 widen the ranging region beyond three slots
  wire chan_wide = chan_set.boundary_code_bits >= BOUNDARY_WIDE;
  wire chan_rng3 = chan_set.ranging_indicator_bit & ~chan_wide;
  // span k of the channel covers slots 9k+1 to 9k+9
  wire [5:0] chan_last_slot = chan_sets * 6'd9;
  wire [31:0] chan_info = {13'h0000, chan_last_slot, chan_wide, chan_rng3,
                           chan_set.boundary_code_bits, chan_set.ranging_indicator_bit,
                           chan_sets[2:0], chan_valid};

  wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, enable_q} :
                       hit_status ? {cell_count_q[14:0], sf_b_q, sf_count_q} :
                       hit_trailer ? {16'h0000, trailer_q} :
                       hit_sel ? {26'h000_0000, chan_sel_q} :
                       hit_info ? chan_info :
                       hit_flag ? {8'h00, flags_q[flag_idx]} : 32'h0000_0000;

  // Read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~hit_any;
    end
  end

  assign PRDATA_O = prdata_q;
  assign PSLVERR_O = pslverr_q;
  assign PREADY_O = 1'b1;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      enable_q <= 1'b0;
      trailer_q <= TRAILER_RST;
      chan_sel_q <= CHAN_SEL_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        enable_q <= PWDATA_I[0];
      end
      if (hit_trailer) begin
        trailer_q <= PWDATA_I[15:0];
      end
      if (hit_sel) begin
        chan_sel_q <= PWDATA_I[5:0];
      end
    end
  end

  // software writes bits 0-17, hardware fills bits 18-23
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_flag
      always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          flags_q[g] <= '0;
        end else if (apb_wr && hit_flag && (flag_idx == 4'(g))) begin
          flags_q[g] <= {flag_crc(PWDATA_I[17:0]), PWDATA_I[17:0]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Payload sequencer
  // ----------------------------------------------------------------
  seq_state_t seq_q;
  logic [3:0] row_q;
  logic [1:0] pos_q;
  logic [2:0] fset_q;
  logic [1:0] fbyte_q;
  logic [5:0] cell_cnt_q;
  logic [7:0] hec_q;
  logic [7:0] rs_r1_q;
  logic [7:0] rs_r0_q;
  logic [2:0] branch_q;
  logic [7:0] il_mem_q [IL_CELLS];
  logic [5:0] il_ptr_q [IL_DEPTH];
  out_beat_t out_q;
  logic out_valid_q;

  wire in_coded = (seq_q == SEQ_CODED);
  wire need_cell = in_coded && (cell_cnt_q < CELL_BYTES);
  wire step = ~out_valid_q | OUT_READY_I;
  wire have = enable_q & (~need_cell | CELL_VALID_I);
  wire fire = step & have;
  assign CELL_READY_O = step & enable_q & need_cell;

  // header byte 5 is replaced by the check over bytes 1-4
  // standard HEC polynomial gives single-correct, multi-detect
  wire [7:0] cell_byte = (cell_cnt_q == HEC_POS) ? (hec_q ^ HEC_COSET) : CELL_DATA_I;
  wire [7:0] parity_byte = (cell_cnt_q == CELL_BYTES) ? rs_r1_q : rs_r0_q;
  wire [7:0] coded_byte = need_cell ? cell_byte : parity_byte;

  // g(x) = x^2 + 3x + 2 in GF(256)
  wire [7:0] rs_fb = cell_byte ^ rs_r1_q;
  wire [7:0] rs_fb2 = gf_mul2(rs_fb);

  // branch j is a ring of 11*j bytes in a shared array
  wire [6:0] il_addr = il_base(int'(branch_q)) + 7'(il_ptr_q[branch_q]);
  // branch 0 passes the byte straight through
  wire [7:0] il_out = (branch_q == 3'd0) ? coded_byte : il_mem_q[il_addr];

  wire last_row = (row_q == ROW_LAST);
  wire tail_flag = row_q[0] & ~last_row;
  wire code_end = in_coded && (cell_cnt_q == CODE_LAST);
  wire tail_end = (seq_q == SEQ_TAIL) && (~last_row || (pos_q == 2'd1));
  wire sf_end = tail_end && last_row;

  flag_set_t cur_set;
  assign cur_set = flags_q[{sf_b_q, fset_q}];
  // each set byte goes out msb first
  wire [7:0] flag_out = flag_byte(cur_set, fbyte_q);
  wire [7:0] trail_out = (pos_q == 2'd0) ? trailer_q[15:8] : trailer_q[7:0];
  // only coded bytes come from the interleaver
  wire [7:0] beat_data = in_coded ? il_out :
                         (seq_q == SEQ_TAIL && last_row) ? trail_out : flag_out;
  wire is_flag = ~in_coded && ~((seq_q == SEQ_TAIL) && last_row);

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || !enable_q) begin
      seq_q <= SEQ_LEAD;
      row_q <= 4'd0;
      pos_q <= 2'd0;
      sf_b_q <= 1'b0;
    end else if (fire) begin
      case (seq_q)
        SEQ_LEAD: begin
          // two flag bytes, then a coded packet starts
          pos_q <= pos_q + 2'd1;
          if (pos_q == 2'd1) begin
            seq_q <= SEQ_CODED;
            pos_q <= 2'd0;
          end
        end
        SEQ_CODED: begin
          if (code_end) begin
            seq_q <= (tail_flag || last_row) ? SEQ_TAIL : SEQ_LEAD;
            row_q <= (tail_flag || last_row) ? row_q : row_q + 4'd1;
          end
        end
        default: begin
          pos_q <= pos_q + 2'd1;
          if (tail_end) begin
            seq_q <= SEQ_LEAD;
            pos_q <= 2'd0;
            // ten packets, then the group restarts with the superframe
            row_q <= last_row ? 4'd0 : row_q + 4'd1;
            sf_b_q <= sf_end ? ~sf_b_q : sf_b_q;
          end
        end
      endcase
    end
  end

  // Flag byte pointer walks R1a..R8c across the superframe
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || !enable_q) begin
      fset_q <= 3'd0;
      fbyte_q <= 2'd0;
    end else if (fire && is_flag) begin
      fbyte_q <= (fbyte_q == SET_BYTE_LAST) ? 2'd0 : fbyte_q + 2'd1;
      if (fbyte_q == SET_BYTE_LAST) begin
        fset_q <= (fset_q == SET_LAST) ? 3'd0 : fset_q + 3'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // HEC and RS encoder
  // ----------------------------------------------------------------
  // leading zeros never disturb a zero-state encoder, so the
  // shortened code starts from a cleared state and emits nothing extra
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || !enable_q) begin
      cell_cnt_q <= 6'd0;
      hec_q <= 8'h00;
      rs_r1_q <= 8'h00;
      rs_r0_q <= 8'h00;
    end else if (fire && in_coded) begin
      cell_cnt_q <= code_end ? 6'd0 : cell_cnt_q + 6'd1;
      if (cell_cnt_q <= HDR_LAST) begin
        hec_q <= hec_step(hec_q, CELL_DATA_I);
      end else if (code_end) begin
        hec_q <= 8'h00;
      end
      // two parity registers for t = 1
      if (need_cell) begin
        rs_r1_q <= rs_r0_q ^ rs_fb2 ^ rs_fb;
        rs_r0_q <= rs_fb2;
      end else if (code_end) begin
        rs_r1_q <= 8'h00;
        rs_r0_q <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Convolutional interleaver
  // ----------------------------------------------------------------
  // five branches on the coded byte stream
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || !enable_q) begin
      branch_q <= 3'd0;
    end else if (fire && in_coded) begin
      // one switch position per byte, in and out together
      branch_q <= (branch_q == IL_BRANCH_LAST) ? 3'd0 : branch_q + 3'd1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (fire && in_coded && branch_q != 3'd0) begin
      il_mem_q[il_addr] <= coded_byte;
    end
  end

  generate
    for (g = 0; g < IL_DEPTH; g++) begin : g_ptr
      always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          il_ptr_q[g] <= 6'd0;
        end else if (fire && in_coded && branch_q == 3'(g) && g != 0) begin
          il_ptr_q[g] <= (il_ptr_q[g] == 6'(IL_M * g - 1)) ? 6'd0 : il_ptr_q[g] + 6'd1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output stage and counters
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end else if (step) begin
      out_valid_q <= fire;
      if (fire) begin
        out_q.data <= beat_data;
        out_q.sof <= (seq_q == SEQ_LEAD) && (row_q == 4'd0) && (pos_q == 2'd0);
        out_q.coded <= in_coded;
      end
    end
  end

  assign OUT_BEAT_O = out_q;
  assign OUT_VALID_O = out_valid_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      sf_count_q <= 16'h0000;
      cell_count_q <= 16'h0000;
    end else begin
      if (fire && sf_end) begin
        sf_count_q <= sf_count_q + 16'h0001;
      end
      if (fire && code_end) begin
        cell_count_q <= cell_count_q + 16'h0001;
      end
    end
  end

endmodule

`default_nettype wire

/* oob_framer_monitor.sv */
// Port checker for the out-of-band framer
`timescale 1ns/1ps
`default_nettype none
module oob_framer_monitor (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [7:0] CELL_DATA_I,
  input wire logic CELL_VALID_I,
  input wire logic CELL_READY_O,
  input wire oob_framer_pkg::out_beat_t OUT_BEAT_O,
  input wire logic OUT_VALID_O,
  input wire logic OUT_READY_I
);
  import oob_framer_pkg::*;
  // ----
  // Beat position within the superframe
  // ----
  logic [9:0] cnt_q;
  logic seen_q;
  wire logic take = OUT_VALID_O && OUT_READY_I;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cnt_q <= 10'h000;
      seen_q <= 1'b0;
    end else if (take) begin
      cnt_q <= OUT_BEAT_O.sof ? 10'h001 : cnt_q + 10'h001;
      seen_q <= seen_q | OUT_BEAT_O.sof;
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_bad_acc;
    PSEL_I && !PENABLE_I && PADDR_I[1:0] != 2'h0 ##1 PSEL_I && PENABLE_I;
  endsequence
  sequence s_ctrl_acc;
    PSEL_I && !PENABLE_I && PADDR_I == 32'h0000_0000 ##1 PSEL_I && PENABLE_I;
  endsequence
  chk_bad_addr: assert property (s_bad_acc |-> PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("misaligned access not refused");
  chk_good_addr: assert property (s_ctrl_acc |-> !PSLVERR_O && PREADY_O)
    else $error("control access refused");
  chk_reset_out: assert property ($fell(RST_I) |-> !OUT_VALID_O && !CELL_READY_O)
    else $error("outputs active after reset");
  chk_beat_hold: assert property (OUT_VALID_O && !OUT_READY_I |=>
    OUT_VALID_O && $stable(OUT_BEAT_O)) else $error("stalled beat changed");
  chk_cell_gate: assert property (CELL_READY_O |-> !OUT_VALID_O || OUT_READY_I)
    else $error("cell taken while output blocked");
  chk_cell_coded: assert property (
    CELL_VALID_I && CELL_READY_O |=> OUT_VALID_O && OUT_BEAT_O.coded)
    else $error("cell byte not sent as coded beat");
  chk_frame_len: assert property (
    take && OUT_BEAT_O.sof && seen_q |-> cnt_q == 10'h240)
    else $error("superframe length wrong");
  chk_flag_bypass: assert property (
    take && seen_q && (cnt_q == 10'h001 || cnt_q == 10'h039 || cnt_q == 10'h23E ||
    cnt_q == 10'h23F) |-> !OUT_BEAT_O.coded) else $error("overhead beat marked coded");
  chk_third_coded: assert property (
    take && seen_q && cnt_q == 10'h002 |-> OUT_BEAT_O.coded)
    else $error("third payload byte not coded");
endmodule
bind oob_framer oob_framer_monitor i_mon (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .CELL_DATA_I(CELL_DATA_I), .CELL_VALID_I(CELL_VALID_I), .CELL_READY_O(CELL_READY_O),
  .OUT_BEAT_O(OUT_BEAT_O), .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I));
`default_nettype wire

/* oob_terminal_model.sv */
// Behavioural subscriber terminal taking the downstream payload beats
`timescale 1ns/1ps
`default_nettype none
module oob_terminal_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire oob_framer_pkg::out_beat_t beat_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic [7:0] sync_byte_o,
  output logic [1:0] rng_slot_o,
  output logic [3:0] ack_per_o
);
  import oob_framer_pkg::*;
  logic [1:0] pos_q;
  logic rng_rx_q;
  logic rng_use_q;
  logic [3:0] per_q;
  // ranging goes only in the middle of three slots
  assign rng_slot_o = rng_use_q ? 2'h2 : 2'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      pos_q <= 2'h3;
      sync_byte_o <= 8'h00;
      rng_rx_q <= 1'b0;
      rng_use_q <= 1'b0;
      per_q <= 4'h0;
      ack_per_o <= 4'h0;
    end else begin
      // Slow mode refuses every other cycle so the framer must stall
      ready_o <= slow_i ? !ready_o : 1'b1;
      if (valid_i && ready_o) begin
        if (beat_i.sof) begin
          pos_q <= 2'h1;
          // ranging bit of this period applies to the next one
          rng_use_q <= rng_rx_q;
          rng_rx_q <= beat_i.data[7];
          // reception bits here refer to two periods back
          per_q <= per_q + 4'h1;
          ack_per_o <= per_q - 4'h2;
        end else if (pos_q != 2'h3) begin
          pos_q <= pos_q + 2'h1;
        end
        if (pos_q == 2'h2) begin
          sync_byte_o <= beat_i.data;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* oob_framer_tb.sv */
// Self-checking bench for the out-of-band framer
`timescale 1ns/1ps
`default_nettype none
module oob_framer_tb;
  import oob_framer_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] cell_data = 8'h03;
  logic cell_valid = 1'b1;
  logic cell_ready;
  out_beat_t beat;
  logic out_valid;
  logic out_ready;
  logic slow = 1'b0;
  logic [7:0] sync_byte;
  logic [1:0] rng_slot;
  logic [3:0] ack_per;
  int num_errors = 0;
  int samples_checked = 0;
  out_beat_t beats [0:599];
  logic [7:0] cd [0:599];
  int nb = 0;
  int nc = 0;
  int ci = 0;
  always #12.5 clk = ~clk;
  oob_framer i_dut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CELL_DATA_I(cell_data),
    .CELL_VALID_I(cell_valid), .CELL_READY_O(cell_ready), .OUT_BEAT_O(beat),
    .OUT_VALID_O(out_valid), .OUT_READY_I(out_ready));
  oob_terminal_model i_term (.clk_i(clk), .rst_i(rst), .slow_i(slow), .beat_i(beat),
    .valid_i(out_valid), .ready_o(out_ready), .sync_byte_o(sync_byte),
    .rng_slot_o(rng_slot), .ack_per_o(ack_per));
  // ----
  // Reference arithmetic
  // ----
  function automatic logic [7:0] cell_byte(input int i);
    return 8'(i * 5 + 3);
  endfunction
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
    end
    return p;
  endfunction
  function automatic logic [7:0] hec();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 4; i++) begin
      c = c ^ cell_byte(i);
      for (int k = 0; k < 8; k++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    end
    return c ^ 8'h55;
  endfunction
  // Leading zero bytes leave the parity state at zero, so they are skipped
  function automatic logic [15:0] parity();
    logic [7:0] r1, r0, fb;
    r1 = 8'h00;
    r0 = 8'h00;
    for (int i = 0; i < 53; i++) begin
      fb = ((i == 4) ? hec() : cell_byte(i)) ^ r1;
      r1 = r0 ^ gmul(fb, 8'h03);
      r0 = gmul(fb, 8'h02);
    end
    return {r1, r0};
  endfunction
  function automatic logic [31:0] flag_rd(input logic [17:0] v);
    logic [5:0] r;
    logic [31:0] w;
    r = 6'h00;
    for (int i = 0; i < 18; i++) r = {r[4:0], 1'b0} ^ ((v[i] ^ r[5]) ? 6'h03 : 6'h00);
    w = {14'h0000, v};
    for (int i = 0; i < 6; i++) w[18 + i] = r[5 - i];
    return w;
  endfunction
  function automatic logic [7:0] fbyte(input logic [31:0] w, input int n);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) b[7 - i] = w[8 * n + i];
    return b;
  endfunction
  // ----
  // Bus and compare tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check(32'(e), 32'(exp_err));
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----
  // Cell source and beat capture
  // ----
  always @(posedge clk) begin
    if (cell_valid && cell_ready) begin
      ci = (ci == 52) ? 0 : ci + 1;
      cell_data <= cell_byte(ci);
    end
    if (out_valid && out_ready && nb < 600) begin
      beats[nb] <= beat;
      nb <= nb + 1;
      if (beat.coded) begin
        cd[nc] <= beat.data;
        nc <= nc + 1;
      end
    end
  end
  logic [5:0] sels [6] = '{6'h00, 6'h11, 6'h10, 6'h0F, 6'h2D, 6'h2E};
  logic [3:0] infos [6] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h9, 4'h8};
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    logic [31:0] w0, w8;
    w0 = flag_rd(18'h2_D6B5);
    w8 = flag_rd(18'h1_3C4E);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(32'h0000_0000, 32'h0000_0000, 1'b0);
    rd(32'h0000_000C, 32'h0000_0001, 1'b0);
    rd(32'h0000_0003, 32'h0000_0000, 1'b1);
    rd(32'h0000_0100, 32'h0000_0000, 1'b1);
    wr(32'h0000_0040, 32'h0002_D6B5);
    wr(32'h0000_0060, 32'h0001_3C4E);
    wr(32'h0000_0008, 32'h0000_A5C3);
    rd(32'h0000_0040, w0, 1'b0);
    rd(32'h0000_0060, w8, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(32'h0000_000C, {26'h000_0000, sels[i]});
      apb(1'b0, 32'h0000_0010, 32'h0000_0000, r, e);
      check(32'(r[3:0]), 32'(infos[i]));
    end
    wr(32'h0000_000C, 32'h0000_0001);
    rd(32'h0000_0010, 32'h0002_4B55, 1'b0);
    $display("test channel table done");
    slow <= 1'b1;
    wr(32'h0000_0000, 32'h0000_0001);
    n = 0;
    while (nb < 600 && n < 5000) begin
      n++;
      @(posedge clk);
    end
    if (n == 5000) num_errors++;
    check(32'(beats[0]), 32'({fbyte(w0, 0), 2'b10}));
    check(32'(beats[1]), 32'({fbyte(w0, 1), 2'b00}));
    check(32'(beats[2]), 32'({cell_byte(0), 2'b01}));
    check(32'(beats[57]), 32'({fbyte(w0, 2), 2'b00}));
    check(32'(beats[574]), 32'({8'hA5, 2'b00}));
    check(32'(beats[575]), 32'({8'hC3, 2'b00}));
    check(32'(beats[576]), 32'({fbyte(w8, 0), 2'b10}));
    check(32'(cd[224]), 32'(hec()));
    check(32'(cd[218]), 32'(parity() >> 8));
    check(32'(cd[274]), 32'(parity() & 16'h00FF));
    check(32'(sync_byte), 32'(cell_byte(0)));
    check(32'(rng_slot), 32'h0000_0002);
    check(32'(ack_per), 32'h0000_000F);
    $display("test stream done");
    print_verdict();
  end
endmodule
`default_nettype wire
